// File: verilog/fcsf_pkg.sv
// shared constants and types for the fifo configuration and flag block
package fcsf_pkg;
	localparam int DEPTH_X18 = 131072;
	localparam int CNT_W = 19;
	localparam int OFS_W = 19;
	localparam int DATA_W = 18;
	localparam int CHUNK_W = 16;
	localparam logic [CNT_W-1:0] COUNT_RESET = 19'h00000;
	localparam logic [DATA_W-1:0] WORD_RESET = 18'h00000;
	localparam logic X18_IN_LEVEL = 1'b1;
	localparam logic X18_OUT_LEVEL = 1'b1;
	localparam logic SERIAL_LD_LEVEL = 1'b1;
	localparam logic [8*OFS_W-1:0] DEFAULT_OFS_TABLE = {19'h003FF, 19'h001FF, 19'h000FF,
		19'h0007F, 19'h0003F, 19'h0001F, 19'h0000F, 19'h00007};
	typedef enum logic [1:0] {
		FCSF_PH_EMPTY_LO = 2'b00,
		FCSF_PH_EMPTY_HI = 2'b01,
		FCSF_PH_FULL_LO = 2'b10,
		FCSF_PH_FULL_HI = 2'b11
	} fcsf_ofs_phase_t;
endpackage

// File: verilog/fcsf_flag_ctrl.sv
// configuration latch, offset programming and status flags of a bus-matching queue
//
// Functional notes
// - serial enable and load low shift offset bit
// - serial enable high freezes offsets in serial method
// - output enable low drives bus, else released
// - reset samples load and selects: defaults, method
// - load low programs offsets, chosen method only
// - offset readback only through parallel outputs
// - widths latched; flags count wider units
// - byte order latched; picks first byte out
// - async timing: empty set read, cleared write
// - sync timing: each flag on own edge; here both flags register on the same mclk edge
// - interspersed parity ignores bits 8, 17, readback invalid
// - non-interspersed ignores bits 16, 17
// - parity placement never touches queue data
// - standard full flag low at depth
// - input ready high at depth plus one
// - input ready counts output register word
// - full/input ready through two stages
// - standard empty flag low when no words
// - output ready clears only on true read
// - empty two stages, output ready three
// - fall-through mode latched at master reset
// - async almost-full asserted on write edge
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps

module fcsf_flag_ctrl #(
	parameter int DEPTH = fcsf_pkg::DEPTH_X18,
	parameter logic X18_IN_LEVEL = fcsf_pkg::X18_IN_LEVEL,
	parameter logic X18_OUT_LEVEL = fcsf_pkg::X18_OUT_LEVEL,
	parameter logic [8*fcsf_pkg::OFS_W-1:0] DEFAULT_OFS = fcsf_pkg::DEFAULT_OFS_TABLE
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic srst,
	input wire logic clkEn,
	// resets and straps
	input wire logic masterResetN,
	input wire logic partialResetN,
	input wire logic offsetLoadStrobeN,
	input wire logic defaultOffsetSel0,
	input wire logic defaultOffsetSel1,
	input wire logic fallthroughSelectSerialIn,
	input wire logic inputWidthSel,
	input wire logic outputWidthSel,
	input wire logic byteOrderSelN,
	input wire logic flagTimingSel,
	input wire logic parityPlacementSel,
	input wire logic serialProgEnableN,
	// write side
	input wire logic writeEnN,
	input wire logic [fcsf_pkg::DATA_W-1:0] dataIn,
	// read side
	input wire logic readEnN,
	input wire logic outputEnN,
	// storage array port
	output logic memWrEn,
	output logic [fcsf_pkg::CNT_W-1:0] memWrAddr,
	output logic [fcsf_pkg::DATA_W-1:0] memWrData,
	output logic [fcsf_pkg::CNT_W-1:0] memRdAddr,
	input wire logic [fcsf_pkg::DATA_W-1:0] memRdData,
	// data bus and flags
	output logic [fcsf_pkg::DATA_W-1:0] dataOutBus,
	output logic dataOutBusOe,
	output logic fullN,
	output logic emptyN,
	output logic almostEmptyN,
	output logic almostFullN
);
	import fcsf_pkg::*;

	if (DEPTH < 2 || 2 * DEPTH + 1 >= 2 ** CNT_W) begin : g_bad_depth
		$error("fcsf_flag_ctrl: DEPTH does not fit the counters");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] fcsfPickByte(input logic [DATA_W-1:0] w,
		input logic little, input logic second);
		fcsfPickByte = (little ^ second) ? w[8:0] : w[17:9];
	endfunction

	function automatic logic [CHUNK_W-1:0] fcsfChunkIn(input logic [DATA_W-1:0] d,
		input logic il);
		fcsfChunkIn = il ? {d[16:9], d[7:0]} : d[15:0];
	endfunction

	function automatic logic [DATA_W-1:0] fcsfChunkOut(input logic [CHUNK_W-1:0] c,
		input logic il);
		fcsfChunkOut = il ? {1'b0, c[15:8], 1'b0, c[7:0]} : {2'b00, c};
	endfunction

	// ----------------------------------------------------------------
	// configuration latched during master reset
	// ----------------------------------------------------------------
	logic cfgFwft_reg, cfgSerial_reg, cfgIn18_reg, cfgOut18_reg;
	logic cfgLittle_reg, cfgSyncFlags_reg, cfgParityIl_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			cfgFwft_reg <= 1'b0;
			cfgSerial_reg <= 1'b0;
			cfgIn18_reg <= 1'b1;
			cfgOut18_reg <= 1'b1;
			cfgLittle_reg <= 1'b0;
			cfgSyncFlags_reg <= 1'b0;
			cfgParityIl_reg <= 1'b0;
		end else if (clkEn && !masterResetN) begin
			cfgFwft_reg <= fallthroughSelectSerialIn;
			cfgSerial_reg <= (offsetLoadStrobeN == SERIAL_LD_LEVEL);
			cfgIn18_reg <= (inputWidthSel == X18_IN_LEVEL);
			cfgOut18_reg <= (outputWidthSel == X18_OUT_LEVEL);
			cfgLittle_reg <= byteOrderSelN;
			cfgSyncFlags_reg <= flagTimingSel;
			cfgParityIl_reg <= parityPlacementSel;
		end
	end

	logic running, ldActive, byteOut, byteIn;
	logic [CNT_W-1:0] capUnits, totalCap;

	assign running = masterResetN && partialResetN;
	assign ldActive = masterResetN && !offsetLoadStrobeN;
	assign byteOut = cfgIn18_reg && !cfgOut18_reg;
	assign byteIn = !cfgIn18_reg && cfgOut18_reg;
	// one unit is a word of the wider port; only x9 on both sides counts bytes
	assign capUnits = (cfgIn18_reg || cfgOut18_reg) ? CNT_W'(DEPTH) : CNT_W'(2 * DEPTH);
	assign totalCap = capUnits + CNT_W'(cfgFwft_reg);

	// ----------------------------------------------------------------
	// offset registers
	// ----------------------------------------------------------------
	logic [OFS_W-1:0] emptyOfs_reg, fullOfs_reg;
	fcsf_ofs_phase_t ofsPhase_reg;
	logic serialShift, parLoad, parRead;
	logic [CHUNK_W-1:0] chunkIn, chunkOut;
	logic [OFS_W-1:0] defaultOfs;

	// serial shift needs both lows and the serial method from reset
	assign serialShift = ldActive && !serialProgEnableN && cfgSerial_reg;
	assign parLoad = ldActive && !cfgSerial_reg && !writeEnN;
	assign parRead = ldActive && !readEnN;
	assign chunkIn = fcsfChunkIn(dataIn, cfgParityIl_reg);
	assign defaultOfs = DEFAULT_OFS[{offsetLoadStrobeN, defaultOffsetSel1, defaultOffsetSel0}
		* OFS_W +: OFS_W];

	always_comb begin
		case (ofsPhase_reg)
			FCSF_PH_EMPTY_LO: chunkOut = emptyOfs_reg[CHUNK_W-1:0];
			FCSF_PH_EMPTY_HI: chunkOut = CHUNK_W'(emptyOfs_reg[OFS_W-1:CHUNK_W]);
			FCSF_PH_FULL_LO: chunkOut = fullOfs_reg[CHUNK_W-1:0];
			FCSF_PH_FULL_HI: chunkOut = CHUNK_W'(fullOfs_reg[OFS_W-1:CHUNK_W]);
			default: chunkOut = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			emptyOfs_reg <= 19'h00000;
			fullOfs_reg <= 19'h00000;
		end else if (clkEn) begin
			if (!masterResetN) begin
				emptyOfs_reg <= defaultOfs;
				fullOfs_reg <= defaultOfs;
			end else if (serialShift) begin
				// empty offset first, least significant bit first
				{fullOfs_reg, emptyOfs_reg} <= {fallthroughSelectSerialIn, fullOfs_reg,
					emptyOfs_reg[OFS_W-1:1]};
			end else if (parLoad) begin
				case (ofsPhase_reg)
					FCSF_PH_EMPTY_LO: emptyOfs_reg[CHUNK_W-1:0] <= chunkIn;
					FCSF_PH_EMPTY_HI: emptyOfs_reg[OFS_W-1:CHUNK_W] <= chunkIn[2:0];
					FCSF_PH_FULL_LO: fullOfs_reg[CHUNK_W-1:0] <= chunkIn;
					FCSF_PH_FULL_HI: fullOfs_reg[OFS_W-1:CHUNK_W] <= chunkIn[2:0];
					default: fullOfs_reg <= fullOfs_reg;
				endcase
			end
		end
	end

	// sequence restarts whenever load is released
	always_ff @(posedge mclk) begin
		if (srst) begin
			ofsPhase_reg <= FCSF_PH_EMPTY_LO;
		end else if (clkEn) begin
			if (!ldActive) begin
				ofsPhase_reg <= FCSF_PH_EMPTY_LO;
			end else if (parLoad || parRead) begin
				case (ofsPhase_reg)
					FCSF_PH_EMPTY_LO: ofsPhase_reg <= FCSF_PH_EMPTY_HI;
					FCSF_PH_EMPTY_HI: ofsPhase_reg <= FCSF_PH_FULL_LO;
					FCSF_PH_FULL_LO: ofsPhase_reg <= FCSF_PH_FULL_HI;
					default: ofsPhase_reg <= FCSF_PH_EMPTY_LO;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// write side: packing and commit
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] fillCount_reg, wrPtr_reg, rdPtr_reg;
	logic outValid_reg, inPhase_reg;
	logic [8:0] inHold_reg;
	logic [CNT_W-1:0] fillTotal;
	logic fullRaw, wrAccept, wrCommit;
	logic [DATA_W-1:0] wrWord;

	assign fillTotal = fillCount_reg + CNT_W'(cfgFwft_reg && outValid_reg);
	// the array itself never takes more than its depth, even before the first fall-through
	assign fullRaw = (fillTotal >= totalCap) || (fillCount_reg >= capUnits);
	// writes are blocked on the live count so the slow flag never lets one overflow
	assign wrAccept = running && offsetLoadStrobeN && !writeEnN && !fullRaw;
	assign wrCommit = wrAccept && !(byteIn && !inPhase_reg);

	always_comb begin
		if (cfgIn18_reg) begin
			wrWord = dataIn;
		end else if (byteIn) begin
			wrWord = cfgLittle_reg ? {dataIn[8:0], inHold_reg} : {inHold_reg, dataIn[8:0]};
		end else begin
			wrWord = {9'h000, dataIn[8:0]};
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			inPhase_reg <= 1'b0;
			inHold_reg <= 9'h000;
		end else if (clkEn) begin
			if (!running) begin
				inPhase_reg <= 1'b0;
			end else if (wrAccept && byteIn) begin
				inPhase_reg <= !inPhase_reg;
				inHold_reg <= dataIn[8:0];
			end
		end
	end

	assign memWrEn = wrCommit && clkEn;
	assign memWrAddr = wrPtr_reg;
	assign memWrData = wrWord;
	assign memRdAddr = rdPtr_reg;

	// ----------------------------------------------------------------
	// read side: fetch, byte step, output register
	// ----------------------------------------------------------------
	logic notEmptyS1_reg, notEmptyS2_reg;
	logic memAvail, rdReq, fetch, stepByte, drop, outValidNext;
	logic outPhase_reg;
	logic [DATA_W-1:0] holdWord_reg, outReg_reg;

	assign memAvail = fillCount_reg != COUNT_RESET;
	assign rdReq = running && offsetLoadStrobeN && !readEnN;

	always_comb begin
		fetch = 1'b0;
		stepByte = 1'b0;
		drop = 1'b0;
		// no fall-through while the offsets own the output register
		if (!running || ldActive) begin
			fetch = 1'b0;
		end else if (cfgFwft_reg) begin
			if (outValid_reg && rdReq && byteOut && outPhase_reg) begin
				stepByte = 1'b1;
			end else if ((!outValid_reg || rdReq) && notEmptyS2_reg && memAvail) begin
				fetch = 1'b1;
			end else if (outValid_reg && rdReq) begin
				drop = 1'b1;
			end
		end else if (rdReq) begin
			if (byteOut && outPhase_reg) begin
				stepByte = 1'b1;
			end else if (notEmptyS2_reg && memAvail) begin
				fetch = 1'b1;
			end
		end
	end

	assign outValidNext = fetch ? 1'b1 : (drop ? 1'b0 : outValid_reg);

	always_ff @(posedge mclk) begin
		if (srst) begin
			outReg_reg <= WORD_RESET;
			holdWord_reg <= WORD_RESET;
			outPhase_reg <= 1'b0;
			outValid_reg <= 1'b0;
		end else if (clkEn) begin
			if (!running) begin
				outPhase_reg <= 1'b0;
				outValid_reg <= 1'b0;
			end else begin
				outValid_reg <= outValidNext;
				if (parRead) begin
					outReg_reg <= fcsfChunkOut(chunkOut, cfgParityIl_reg);
				end else if (fetch) begin
					holdWord_reg <= memRdData;
					outPhase_reg <= byteOut;
					outReg_reg <= byteOut ? {9'h000, fcsfPickByte(memRdData, cfgLittle_reg, 1'b0)}
						: memRdData;
				end else if (stepByte) begin
					outPhase_reg <= 1'b0;
					outReg_reg <= {9'h000, fcsfPickByte(holdWord_reg, cfgLittle_reg, 1'b1)};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pointers and fill count
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] fillNext, totalNext;

	always_comb begin
		fillNext = fillCount_reg;
		if (wrCommit && !fetch) begin
			fillNext = fillCount_reg + 19'h00001;
		end else if (fetch && !wrCommit) begin
			fillNext = fillCount_reg - 19'h00001;
		end
	end

	assign totalNext = fillNext + CNT_W'(cfgFwft_reg && outValidNext);

	always_ff @(posedge mclk) begin
		if (srst) begin
			fillCount_reg <= COUNT_RESET;
			wrPtr_reg <= COUNT_RESET;
			rdPtr_reg <= COUNT_RESET;
		end else if (clkEn) begin
			if (!running) begin
				fillCount_reg <= COUNT_RESET;
				wrPtr_reg <= COUNT_RESET;
				rdPtr_reg <= COUNT_RESET;
			end else begin
				fillCount_reg <= fillNext;
				if (wrCommit) begin
					wrPtr_reg <= (wrPtr_reg == capUnits - 19'h00001) ? COUNT_RESET
						: wrPtr_reg + 19'h00001;
				end
				if (fetch) begin
					rdPtr_reg <= (rdPtr_reg == capUnits - 19'h00001) ? COUNT_RESET
						: rdPtr_reg + 19'h00001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// full / input ready and empty / output ready
	// ----------------------------------------------------------------
	logic fullS1_reg, fullS2_reg;

	always_ff @(posedge mclk) begin
		if (srst) begin
			fullS1_reg <= 1'b0;
			fullS2_reg <= 1'b0;
			notEmptyS1_reg <= 1'b0;
			notEmptyS2_reg <= 1'b0;
		end else if (clkEn) begin
			fullS1_reg <= running && fullRaw;
			fullS2_reg <= fullS1_reg;
			notEmptyS1_reg <= running && memAvail;
			notEmptyS2_reg <= running && notEmptyS1_reg;
		end
	end

	assign fullN = cfgFwft_reg ? fullS2_reg : !fullS2_reg;
	assign emptyN = cfgFwft_reg ? !outValid_reg : notEmptyS2_reg;

	// ----------------------------------------------------------------
	// almost flags
	// ----------------------------------------------------------------
	logic aeCond, afCond;

	assign aeCond = cfgFwft_reg ? ({1'b0, totalNext} <= {1'b0, emptyOfs_reg} + 20'h00001)
		: (fillNext <= emptyOfs_reg);
	assign afCond = {1'b0, totalNext} + {1'b0, fullOfs_reg} >= {1'b0, totalCap};

	always_ff @(posedge mclk) begin
		if (srst) begin
			almostEmptyN <= 1'b0;
			almostFullN <= 1'b1;
		end else if (clkEn) begin
			if (!running) begin
				almostEmptyN <= 1'b0;
				almostFullN <= 1'b1;
			end else if (cfgSyncFlags_reg) begin
				almostEmptyN <= !aeCond;
				almostFullN <= !afCond;
			end else begin
				// async timing: each flag is set by one side and released by the other
				if (fetch && aeCond) begin
					almostEmptyN <= 1'b0;
				end else if (wrCommit && !aeCond) begin
					almostEmptyN <= 1'b1;
				end
				if (wrCommit && afCond) begin
					almostFullN <= 1'b0;
				end else if (fetch && !afCond) begin
					almostFullN <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// data bus
	// ----------------------------------------------------------------
	assign dataOutBus = outReg_reg;
	assign dataOutBusOe = !outputEnN;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	property p_serial_hold;
		(clkEn && masterResetN && cfgSerial_reg && serialProgEnableN) |=>
			$stable({fullOfs_reg, emptyOfs_reg});
	endproperty
	a_serial_hold: assert property (p_serial_hold) else $error("offsets moved with serial off");

	property p_serial_shift;
		(clkEn && serialShift) |=> fullOfs_reg[OFS_W-1] == $past(fallthroughSelectSerialIn);
	endproperty
	a_serial_shift: assert property (p_serial_shift) else $error("serial bit not taken");

	property p_bus_drive;
		!outputEnN |-> dataOutBusOe && dataOutBus == outReg_reg;
	endproperty
	a_bus_drive: assert property (p_bus_drive) else $error("output bus not driven");

	property p_no_overflow;
		fillTotal <= totalCap && !(fullRaw && wrCommit);
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("write past capacity");

	property p_std_full;
		(clkEn && running && !cfgFwft_reg && fullRaw)[*3] |-> !fullN;
	endproperty
	a_std_full: assert property (p_std_full) else $error("full flag missing");

	property p_fall_through_mode_ready;
		(clkEn && running && cfgFwft_reg && fullRaw)[*3] |-> fullN;
	endproperty
	a_fall_through_mode_ready: assert property (p_fall_through_mode_ready) else $error("input ready not high");

	property p_std_empty;
		(clkEn && running && !cfgFwft_reg && memAvail)[*3] |-> emptyN;
	endproperty
	a_std_empty: assert property (p_std_empty) else $error("empty flag stuck low");

	property p_or_hold;
		(clkEn && running && cfgFwft_reg && !emptyN && !rdReq) |=> !emptyN;
	endproperty
	a_or_hold: assert property (p_or_hold) else $error("output ready lost without read");

	property p_endian;
		(clkEn && fetch && byteOut && !parRead) |=>
			outReg_reg[8:0] == ($past(cfgLittle_reg) ? $past(memRdData[8:0])
				: $past(memRdData[17:9]));
	endproperty
	a_endian: assert property (p_endian) else $error("wrong first byte");

	property p_sync_ae;
		(clkEn && running && cfgSyncFlags_reg) |=> almostEmptyN == !$past(aeCond);
	endproperty
	a_sync_ae: assert property (p_sync_ae) else $error("almost-empty not updated");
endmodule // fcsf_flag_ctrl

// File: test/fcsf_mem_model.sv
// storage array model behind the queue port
`timescale 1ns/1ps

module fcsf_mem_model
	import fcsf_pkg::*;
(
	// clock
	input wire logic mclk,
	// write port
	input wire logic memWrEn,
	input wire logic [fcsf_pkg::CNT_W-1:0] memWrAddr,
	input wire logic [fcsf_pkg::DATA_W-1:0] memWrData,
	// read port
	input wire logic [fcsf_pkg::CNT_W-1:0] memRdAddr,
	output logic [fcsf_pkg::DATA_W-1:0] memRdData
);
	logic [DATA_W-1:0] store [64];
	// unwritten cells hold a stripe, so a stale fetch never looks like data
	initial begin
		for (int i = 0; i < 64; i++) begin
			store[i] = 18'h2AAAA ^ DATA_W'(i);
		end
	end
	// words are kept exactly as written
	always @(posedge mclk) begin
		if (memWrEn) begin
			store[memWrAddr[5:0]] <= memWrData;
		end
	end
	assign memRdData = store[memRdAddr[5:0]];
endmodule // fcsf_mem_model

// File: test/fcsf_flag_ctrl_tb.sv
// self-checking bench for the queue configuration and flag block
`timescale 1ns/1ps

module fcsf_flag_ctrl_tb;
	import fcsf_pkg::*;
	// ------
	// signals
	// ------
	localparam int TB_DEPTH = 8;
	// cfg: fall-through, input width, output width, byte order, flag timing, parity
	localparam logic [5:0] CASES [8] = '{6'h18, 6'h10, 6'h14, 6'h08, 6'h0C, 6'h01, 6'h3B, 6'h24};
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic clkEn = 1'b1;
	logic masterResetN = 1'b1;
	logic partialResetN = 1'b1;
	logic offsetLoadStrobeN = 1'b1;
	logic defaultOffsetSel0 = 1'b0;
	logic defaultOffsetSel1 = 1'b0;
	logic fallthroughSelectSerialIn = 1'b0;
	logic inputWidthSel = 1'b1;
	logic outputWidthSel = 1'b1;
	logic byteOrderSelN = 1'b0;
	logic flagTimingSel = 1'b0;
	logic parityPlacementSel = 1'b0;
	logic serialProgEnableN = 1'b1;
	logic writeEnN = 1'b1;
	logic readEnN = 1'b1;
	logic outputEnN = 1'b0;
	logic [DATA_W-1:0] dataIn = WORD_RESET;
	logic memWrEn;
	logic [CNT_W-1:0] memWrAddr;
	logic [CNT_W-1:0] memRdAddr;
	logic [DATA_W-1:0] memWrData;
	logic [DATA_W-1:0] memRdData;
	logic [DATA_W-1:0] dataOutBus;
	logic dataOutBusOe;
	logic fullN;
	logic emptyN;
	logic almostEmptyN;
	logic almostFullN;
	logic [DATA_W-1:0] inUnits [40];
	logic [OFS_W-1:0] ofsN;
	logic [OFS_W-1:0] ofsM;
	int lvl;
	int miscompares = 0;
	int comparisons = 0;

	always #5 mclk = ~mclk;

	fcsf_flag_ctrl #(.DEPTH(TB_DEPTH)) fcsf_flag_ctrl_i (.mclk(mclk), .srst(srst), .clkEn(clkEn),
		.masterResetN(masterResetN), .partialResetN(partialResetN),
		.offsetLoadStrobeN(offsetLoadStrobeN), .defaultOffsetSel0(defaultOffsetSel0),
		.defaultOffsetSel1(defaultOffsetSel1), .fallthroughSelectSerialIn(fallthroughSelectSerialIn),
		.inputWidthSel(inputWidthSel), .outputWidthSel(outputWidthSel),
		.byteOrderSelN(byteOrderSelN), .flagTimingSel(flagTimingSel),
		.parityPlacementSel(parityPlacementSel), .serialProgEnableN(serialProgEnableN),
		.writeEnN(writeEnN), .dataIn(dataIn), .readEnN(readEnN), .outputEnN(outputEnN),
		.memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData), .memRdAddr(memRdAddr),
		.memRdData(memRdData), .dataOutBus(dataOutBus), .dataOutBusOe(dataOutBusOe),
		.fullN(fullN), .emptyN(emptyN), .almostEmptyN(almostEmptyN), .almostFullN(almostFullN));

	fcsf_mem_model fcsf_mem_model_i (.mclk(mclk), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
		.memWrData(memWrData), .memRdAddr(memRdAddr), .memRdData(memRdData));

	// ------
	// tasks
	// ------
	task automatic check(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// one request, then idle cycles with both enables released
	task automatic drive(input logic wr, input logic rd, input logic [DATA_W-1:0] d,
		input int idle);
		@(posedge mclk);
		writeEnN <= !wr;
		readEnN <= !rd;
		dataIn <= d;
		repeat (idle) begin
			@(posedge mclk);
			writeEnN <= 1'b1;
			readEnN <= 1'b1;
		end
	endtask

	task automatic mreset(input logic [2:0] idx, input logic [5:0] cfg);
		@(posedge mclk);
		masterResetN <= 1'b0;
		{offsetLoadStrobeN, defaultOffsetSel1, defaultOffsetSel0} <= idx;
		{fallthroughSelectSerialIn, inputWidthSel, outputWidthSel} <= cfg[5:3];
		{byteOrderSelN, flagTimingSel, parityPlacementSel} <= cfg[2:0];
		repeat (2) @(posedge mclk);
		masterResetN <= 1'b1;
		offsetLoadStrobeN <= 1'b1;
		fallthroughSelectSerialIn <= 1'b0;
	endtask

	function automatic logic [4*CHUNK_W-1:0] chunks(input logic [OFS_W-1:0] n,
		input logic [OFS_W-1:0] m);
		return {13'h0000, m[18:16], m[15:0], 13'h0000, n[18:16], n[15:0]};
	endfunction

	task automatic pload(input logic [OFS_W-1:0] n, input logic [OFS_W-1:0] m);
		logic [4*CHUNK_W-1:0] c;
		c = chunks(n, m);
		@(posedge mclk);
		offsetLoadStrobeN <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			writeEnN <= 1'b0;
			dataIn <= {2'($urandom), c[k*CHUNK_W +: CHUNK_W]};
			@(posedge mclk);
		end
		offsetLoadStrobeN <= 1'b1;
		writeEnN <= 1'b1;
	endtask

	// every other cycle the enable is high with junk on the serial line
	task automatic sload(input logic [2*OFS_W-1:0] bits);
		@(posedge mclk);
		offsetLoadStrobeN <= 1'b0;
		for (int k = 0; k < 2 * OFS_W; k++) begin
			serialProgEnableN <= 1'b0;
			fallthroughSelectSerialIn <= bits[k];
			@(posedge mclk);
			serialProgEnableN <= 1'b1;
			fallthroughSelectSerialIn <= 1'($urandom);
			@(posedge mclk);
		end
		offsetLoadStrobeN <= 1'b1;
	endtask

	task automatic readback(input logic [OFS_W-1:0] n, input logic [OFS_W-1:0] m);
		logic [4*CHUNK_W-1:0] c;
		c = chunks(n, m);
		@(posedge mclk);
		offsetLoadStrobeN <= 1'b0;
		readEnN <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			if (k == 3) begin
				offsetLoadStrobeN <= 1'b1;
				readEnN <= 1'b1;
			end
			@(negedge mclk);
			check("offset chunk", DATA_W'(c[k*CHUNK_W +: CHUNK_W]),
				DATA_W'(dataOutBus[15:0]));
		end
	endtask

	function automatic logic [DATA_W-1:0] exp_out(input int k, input logic [5:0] cfg);
		logic iw9;
		logic ow9;
		logic [DATA_W-1:0] w;
		iw9 = cfg[4] != X18_IN_LEVEL;
		ow9 = cfg[3] != X18_OUT_LEVEL;
		w = inUnits[k/2];
		if (!iw9 && ow9) begin
			return ((k % 2 == 0) != cfg[2]) ? DATA_W'(w[17:9]) : DATA_W'(w[8:0]);
		end
		if (iw9 && !ow9) begin
			return cfg[2] ? {inUnits[2*k+1][8:0], inUnits[2*k][8:0]} :
				{inUnits[2*k][8:0], inUnits[2*k+1][8:0]};
		end
		return inUnits[k];
	endfunction

	// fill to the refusal point, then drain one unit at a time
	task automatic run_queue(input logic [5:0] cfg);
		logic iw9;
		logic ow9;
		logic fw;
		logic [DATA_W-1:0] mask;
		int cap;
		int units;
		int outs;
		fw = cfg[5];
		iw9 = cfg[4] != X18_IN_LEVEL;
		ow9 = cfg[3] != X18_OUT_LEVEL;
		mask = ow9 ? 18'h001FF : 18'h3FFFF;
		cap = ((iw9 && ow9) ? 2 * TB_DEPTH : TB_DEPTH) + int'(fw);
		units = (iw9 && !ow9) ? 2 * cap : cap;
		outs = (!iw9 && ow9) ? 2 * units : ((iw9 && !ow9) ? units / 2 : units);
		for (int k = 0; k < units; k++) begin
			inUnits[k] = iw9 ? DATA_W'($urandom_range(511)) : DATA_W'($urandom);
		end
		mreset(3'h0, cfg);
		for (int k = 0; k < units - 1; k++) begin
			drive(1'b1, 1'b0, inUnits[k], 0);
		end
		drive(1'b0, 1'b0, WORD_RESET, 4);
		@(negedge mclk);
		check("fullN open", DATA_W'(!fw), DATA_W'(fullN));
		drive(1'b1, 1'b0, inUnits[units-1], 2);
		@(negedge mclk);
		check("fullN stage", DATA_W'(!fw), DATA_W'(fullN));
		@(negedge mclk);
		check("fullN at depth", DATA_W'(fw), DATA_W'(fullN));
		drive(1'b1, 1'b0, ~inUnits[0], 0);
		@(negedge mclk);
		check("memWrEn refused", WORD_RESET, DATA_W'(memWrEn));
		drive(1'b0, 1'b0, WORD_RESET, 5);
		for (int k = 0; k < outs; k++) begin
			@(negedge mclk);
			if (fw || k < outs - 1) begin
				check("emptyN held", DATA_W'(!fw), DATA_W'(emptyN));
			end
			if (fw) begin
				check("word shown", exp_out(k, cfg) & mask, dataOutBus & mask);
			end
			drive(1'b0, 1'b1, WORD_RESET, 5);
			outputEnN <= 1'($urandom);
			@(negedge mclk);
			check("dataOutBusOe", DATA_W'(!outputEnN), DATA_W'(dataOutBusOe));
			if (!fw) begin
				check("word read", exp_out(k, cfg) & mask, dataOutBus & mask);
			end
		end
		check("emptyN drained", DATA_W'(fw), DATA_W'(emptyN));
		check("last word kept", exp_out(outs - 1, cfg) & mask, dataOutBus & mask);
	endtask

	// ------
	// main sequence
	// ------
	initial begin
		void'($urandom(83));
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		check("fullN reset", 18'h00001, DATA_W'(fullN));
		check("emptyN reset", WORD_RESET, DATA_W'(emptyN));
		check("dataOutBus reset", WORD_RESET, dataOutBus);
		for (int i = 0; i < 8; i++) begin
			mreset(3'(i), 6'h18);
			readback(DEFAULT_OFS_TABLE[i*OFS_W +: OFS_W], DEFAULT_OFS_TABLE[i*OFS_W +: OFS_W]);
		end
		ofsN = OFS_W'($urandom);
		ofsM = OFS_W'($urandom);
		mreset(3'h0, 6'h18);
		pload(ofsN, ofsM);
		sload(38'($urandom));
		readback(ofsN, ofsM);
		mreset(3'h4, 6'h18);
		sload({ofsM, ofsN});
		pload(~ofsN, ~ofsM);
		readback(ofsN, ofsM);
		for (int p = 0; p < 2; p++) begin
			mreset(3'h0, 6'h18 | 6'(2 * p));
			pload(19'h00002, 19'h00002);
			for (int k = 1; k <= 2 * TB_DEPTH; k++) begin
				lvl = (k <= TB_DEPTH) ? k : 2 * TB_DEPTH - k;
				drive(k <= TB_DEPTH, k > TB_DEPTH, DATA_W'($urandom), 3);
				@(negedge mclk);
				check("almostEmptyN", DATA_W'(lvl > 2), DATA_W'(almostEmptyN));
				check("almostFullN", DATA_W'(lvl + 2 < TB_DEPTH), DATA_W'(almostFullN));
				check("emptyN level", DATA_W'(lvl > 0), DATA_W'(emptyN));
			end
		end
		for (int i = 0; i < 8; i++) begin
			run_queue(CASES[i]);
		end
		// clock enable low freezes everything; partial reset then empties the queue
		mreset(3'h0, 6'h18);
		drive(1'b1, 1'b0, WORD_RESET, 4);
		@(posedge mclk);
		clkEn <= 1'b0;
		writeEnN <= 1'b0;
		repeat (3) @(negedge mclk);
		check("memWrEn frozen", WORD_RESET, DATA_W'(memWrEn));
		check("emptyN frozen", 18'h00001, DATA_W'(emptyN));
		@(posedge mclk);
		clkEn <= 1'b1;
		writeEnN <= 1'b1;
		partialResetN <= 1'b0;
		@(posedge mclk);
		partialResetN <= 1'b1;
		@(negedge mclk);
		check("emptyN cleared", WORD_RESET, DATA_W'(emptyN));
		check("almostEmptyN cleared", WORD_RESET, DATA_W'(almostEmptyN));
		final_report();
	end
endmodule // fcsf_flag_ctrl_tb
